// >>> hdl/supply_fault_device.sv
// Purpose: Supervisor end: fault summary, input functions, threshold levels, status link.
// Assumes: Runs on the free-running link clock; rst_n is synchronous to it.
// Notes: Nonvolatile inputs are static words; comparator and pin inputs are resynchronised.
`timescale 1ns/1ps

// Operation
// - Summary read returns present comparator state
// - Channel n flags at 2n, 2n-1
// - Upper sense selects above or below
// - Lower sense selects below or above
// - Margin and UV-ignore inputs suppress flags
// - Load nonvolatile configuration before operating
// - Medium range: 0.9V plus 20mV steps
// - Low range: 0.45V plus 10mV steps
// - Precision range: 0.18V plus 4mV steps
// - Host programs unused channels quiet
// - Auxiliary comparator with selectable sense
// - Manual reset active low clears log
// - Manual reset joins faults into reset
// - UV ignore drops undervoltage-type flags
// - Margin hold drops all flags
// - Range field picks medium, low, precision
module supply_fault_device #(
  parameter int LOAD_CYCLES = supply_fault_pkg::POWERUP_LOAD_CYCLES
) (
  supply_link_if.device link,
  input wire logic rst_n,
  input wire supply_fault_pkg::flags6_t upperAbove,
  input wire supply_fault_pkg::flags6_t lowerAbove,
  input wire logic [1:0] generalInputPin,
  input wire logic [1:0] auxAboveRef,
  input wire supply_fault_pkg::word6_t nvSetup,
  input wire supply_fault_pkg::word6_t nvThreshold,
  input wire supply_fault_pkg::func2_t nvFunction,
  input wire logic [1:0] nvClearLogEnable,
  input wire logic [1:0] nvResetIncludesMr,
  output logic loadDone,
  output supply_fault_pkg::mv6_t upperThresholdMv,
  output supply_fault_pkg::mv6_t lowerThresholdMv,
  output logic [15:0] liveSummary,
  output logic [1:0] auxResult,
  output logic clearFaultLog,
  output logic sysReset_n
);
  import supply_fault_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  typedef enum logic [1:0] {
    LOADING = 2'b01,
    RUNNING = 2'b10
  } load_state_t;

  localparam int SYNC_W = 2 * NUM_CHANNELS + 2 * NUM_INPUTS;

  load_state_t loadState;
  logic [15:0] loadCount;
  word6_t setupReg;
  word6_t thresholdReg;
  func2_t functionReg;
  logic [1:0] clearEnableReg;
  logic [1:0] mrToResetReg;

  logic [SYNC_W-1:0] pinSync1;
  logic [SYNC_W-1:0] pinSync2;
  flags6_t upperSeen;
  flags6_t lowerSeen;
  logic [1:0] inputLevel;
  logic [1:0] auxSeen;

  logic [1:0] marginActive;
  logic [1:0] uvIgnoreActive;
  logic [1:0] manualResetLow;
  logic [1:0] next_auxResult;
  logic anyMargin;
  logic anyUvIgnore;
  logic next_clearLog;
  logic next_sysReset_n;
  flags6_t upperKept;
  flags6_t lowerKept;
  flags6_t resetFaults;
  logic [15:0] next_summary;
  mv6_t next_upperMv;
  mv6_t next_lowerMv;

  logic [4:0] bitCount;
  logic [7:0] cmdShift;
  logic [16:0] replyShift;
  logic [7:0] fullCmd;
  logic cmdAccepted;

  // ************************************************************
  // Input resynchronisers
  // ************************************************************
  always_ff @(posedge link.linkClk) begin
    if (!rst_n) begin
      pinSync1 <= '0;
      pinSync2 <= '0;
    end else begin
      pinSync1 <= {auxAboveRef, generalInputPin, lowerAbove, upperAbove};
      pinSync2 <= pinSync1;
    end
  end

  assign upperSeen = pinSync2[NUM_CHANNELS-1:0];
  assign lowerSeen = pinSync2[2*NUM_CHANNELS-1:NUM_CHANNELS];
  assign inputLevel = pinSync2[2*NUM_CHANNELS+1:2*NUM_CHANNELS];
  assign auxSeen = pinSync2[SYNC_W-1:2*NUM_CHANNELS+2];

  // ************************************************************
  // Power-up configuration load
  // ************************************************************
  // Operating registers stay zero until the copy; loadDone keeps the summary clear, but the levels read the 900 mV medium base
  always_ff @(posedge link.linkClk) begin
    if (!rst_n) begin
      loadState <= LOADING;
      loadCount <= 16'h0000;
      setupReg <= '0;
      thresholdReg <= '0;
      functionReg <= '0;
      clearEnableReg <= 2'b00;
      mrToResetReg <= 2'b00;
    end else begin
      unique case (loadState)
        LOADING: begin
          loadCount <= loadCount + 16'h0001;
          if (loadCount == 16'(LOAD_CYCLES - 1)) begin
            setupReg <= nvSetup;
            thresholdReg <= nvThreshold;
            functionReg <= nvFunction;
            clearEnableReg <= nvClearLogEnable;
            mrToResetReg <= nvResetIncludesMr;
            loadState <= RUNNING;
          end
        end
        RUNNING: begin
          loadState <= RUNNING;
        end
      endcase
    end
  end

  assign loadDone = (loadState == RUNNING);

  // ************************************************************
  // General input functions
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_input
      assign marginActive[gi] = (functionReg[gi] == FUNC_MARGIN_HOLD) && !inputLevel[gi];
      assign uvIgnoreActive[gi] = (functionReg[gi] == FUNC_UV_IGNORE) && !inputLevel[gi];
      assign manualResetLow[gi] =
        (functionReg[gi] == FUNC_MANUAL_RESET) && !inputLevel[gi];
      // Inverting hookup flips the sense of the reference comparison
      assign next_auxResult[gi] =
        ((functionReg[gi] == FUNC_AUX_NONINV) && auxSeen[gi]) ||
        ((functionReg[gi] == FUNC_AUX_INV) && !auxSeen[gi]);
    end
  endgenerate

  assign anyMargin = |marginActive;
  assign anyUvIgnore = |uvIgnoreActive;
  assign next_clearLog = |(manualResetLow & clearEnableReg);

  // ************************************************************
  // Per-channel flags and thresholds
  // ************************************************************
  genvar ci;
  generate
    for (ci = 0; ci < NUM_CHANNELS; ci++) begin : g_chan
      logic upperSense;
      logic lowerSense;
      logic upperFlag;
      logic lowerFlag;
      logic [1:0] rangeSel;
      assign upperSense = setupReg[ci][SETUP_UPPER_SENSE_BIT];
      assign lowerSense = setupReg[ci][SETUP_LOWER_SENSE_BIT];
      assign upperFlag = upperSense ? upperSeen[ci] : !upperSeen[ci];
      assign lowerFlag = lowerSense ? lowerSeen[ci] : !lowerSeen[ci];
      // A flag armed for below-threshold is undervoltage-type
      assign upperKept[ci] = upperFlag && !anyMargin &&
        !(anyUvIgnore && !upperSense);
      assign lowerKept[ci] = lowerFlag && !anyMargin &&
        !(anyUvIgnore && !lowerSense);
      assign resetFaults[ci] =
        (upperKept[ci] && setupReg[ci][SETUP_UPPER_TO_RESET_BIT]) ||
        (lowerKept[ci] && setupReg[ci][SETUP_LOWER_TO_RESET_BIT]);
      assign rangeSel = setupReg[ci][SETUP_RANGE_LSB+1:SETUP_RANGE_LSB];
      assign next_upperMv[ci] =
        thresholdMv(thresholdReg[ci][THR_UPPER_LSB+7:THR_UPPER_LSB],
                    rangeSel);
      assign next_lowerMv[ci] =
        thresholdMv(thresholdReg[ci][THR_LOWER_LSB+7:THR_LOWER_LSB],
                    rangeSel);
      assign next_summary[SUMMARY_UPPER_BASE+2*ci] = loadDone && upperKept[ci];
      assign next_summary[SUMMARY_LOWER_BASE+2*ci] = loadDone && lowerKept[ci];
    end
  endgenerate

  // Reserved summary bits read as zero
  assign next_summary[15:13] = 3'b000;
  assign next_summary[0] = 1'b0;

  // Manual reset joins the mapped faults; output is active low
  assign next_sysReset_n = !(|resetFaults || |(manualResetLow & mrToResetReg));

  // ************************************************************
  // Output registers
  // ************************************************************
  // Refreshed every cycle: a snapshot, never held across a fault's end
  always_ff @(posedge link.linkClk) begin
    if (!rst_n) begin
      liveSummary <= SUMMARY_RESET;
      upperThresholdMv <= '0;
      lowerThresholdMv <= '0;
      auxResult <= 2'b00;
      clearFaultLog <= 1'b0;
      sysReset_n <= 1'b1;
    end else begin
      liveSummary <= next_summary;
      upperThresholdMv <= next_upperMv;
      lowerThresholdMv <= next_lowerMv;
      auxResult <= next_auxResult;
      clearFaultLog <= next_clearLog;
      sysReset_n <= next_sysReset_n;
    end
  end

  // ************************************************************
  // Status link
  // ************************************************************
  // Unknown commands and reads during the load answer with ack low and zero data
  assign fullCmd = {cmdShift[6:0], link.cmdBit};
  assign cmdAccepted = loadDone && (fullCmd == CMD_LIVE_FAULT_SUMMARY);
  assign link.replyBit = replyShift[16];

  always_ff @(posedge link.linkClk) begin
    if (!rst_n) begin
      bitCount <= 5'h00;
      cmdShift <= 8'h00;
      replyShift <= 17'h00000;
    end else if (!link.frameActive) begin
      bitCount <= 5'h00;
      cmdShift <= 8'h00;
      replyShift <= 17'h00000;
    end else if (bitCount < 5'(CMD_BITS)) begin
      cmdShift <= fullCmd;
      bitCount <= bitCount + 5'h01;
      if (bitCount == 5'(CMD_BITS - 1)) begin
        replyShift <= {cmdAccepted,
                       cmdAccepted ? liveSummary : REFUSED_REPLY};
      end
    end else begin
      replyShift <= {replyShift[15:0], 1'b0};
    end
  end

  // Unused channels stay quiet only if the host writes the quiet setup words
  // so the summary path needs no special case for them
endmodule

// >>> include/supply_fault_pkg.sv
// Purpose: Shared constants, types and threshold arithmetic for the supply fault link.
// Assumes: Six supervised channels, two general inputs, 16-bit summary word.
// Notes: Threshold arithmetic is shared by both ends so that code and level agree.
package supply_fault_pkg;

  // ************************************************************
  // Sizes and command
  // ************************************************************
  localparam int NUM_CHANNELS = 6;
  localparam int NUM_INPUTS = 2;
  localparam int CMD_BITS = 8;
  localparam int REPLY_BITS = 16;
  localparam logic [7:0] CMD_LIVE_FAULT_SUMMARY = 8'h1f;
  localparam logic [15:0] SUMMARY_RESET = 16'h0000;
  localparam logic [15:0] REFUSED_REPLY = 16'h0000;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SUMMARY_LOWER_BASE = 1;
  localparam int SUMMARY_UPPER_BASE = 2;
  localparam int SETUP_RANGE_LSB = 8;
  localparam int SETUP_UPPER_SENSE_BIT = 7;
  localparam int SETUP_LOWER_SENSE_BIT = 6;
  localparam int SETUP_UPPER_TO_RESET_BIT = 3;
  localparam int SETUP_LOWER_TO_RESET_BIT = 0;
  localparam int THR_UPPER_LSB = 8;
  localparam int THR_LOWER_LSB = 0;

  // ************************************************************
  // Encodings
  // ************************************************************
  localparam logic [1:0] RANGE_MEDIUM = 2'b00;
  localparam logic [1:0] RANGE_LOW = 2'b01;
  localparam logic [2:0] FUNC_MANUAL_RESET = 3'b001;
  localparam logic [2:0] FUNC_MARGIN_HOLD = 3'b010;
  localparam logic [2:0] FUNC_UV_IGNORE = 3'b011;
  localparam logic [2:0] FUNC_AUX_NONINV = 3'b100;
  localparam logic [2:0] FUNC_AUX_INV = 3'b101;
  localparam logic [15:0] UNUSED_SETUP = 16'h01c0;
  localparam logic [15:0] UNUSED_THRESHOLD = 16'h0000;

  // ************************************************************
  // Threshold scales in millivolts
  // ************************************************************
  localparam logic [12:0] MED_BASE_MV = 13'h0384;
  localparam logic [12:0] MED_STEP_MV = 13'h0014;
  localparam logic [12:0] LOW_BASE_MV = 13'h01c2;
  localparam logic [12:0] LOW_STEP_MV = 13'h000a;
  localparam logic [12:0] PREC_BASE_MV = 13'h00b4;
  localparam logic [12:0] PREC_STEP_MV = 13'h0004;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int POWERUP_LOAD_US = 200;
  localparam int LINK_PERIOD_NS = 32;
  localparam int POWERUP_LOAD_CYCLES = (POWERUP_LOAD_US * 1000) / LINK_PERIOD_NS;
  localparam int LINK_HALF_REF_CYCLES = 3;

  typedef logic [12:0] mv_t;
  typedef logic [7:0] code_t;
  typedef logic [5:0] flags6_t;
  typedef logic [5:0][15:0] word6_t;
  typedef logic [5:0][12:0] mv6_t;
  typedef logic [1:0][2:0] func2_t;

  function automatic mv_t rangeBase(input logic [1:0] range);
    mv_t base;
    base = PREC_BASE_MV;
    if (range == RANGE_MEDIUM) begin
      base = MED_BASE_MV;
    end else if (range == RANGE_LOW) begin
      base = LOW_BASE_MV;
    end
    return base;
  endfunction

  function automatic mv_t rangeStep(input logic [1:0] range);
    mv_t step;
    step = PREC_STEP_MV;
    if (range == RANGE_MEDIUM) begin
      step = MED_STEP_MV;
    end else if (range == RANGE_LOW) begin
      step = LOW_STEP_MV;
    end
    return step;
  endfunction

  // Level for a code: base plus one step per count
  function automatic mv_t thresholdMv(input code_t code, input logic [1:0] range);
    return mv_t'(rangeBase(range) + rangeStep(range) * mv_t'(code));
  endfunction

  // Code for a level, rounded to nearest and clamped to the code range
  function automatic code_t thresholdCode(input mv_t mv, input logic [1:0] range);
    logic [13:0] offset;
    logic [13:0] quotient;
    offset = 14'h0000;
    quotient = 14'h0000;
    if (mv > rangeBase(range)) begin
      offset = 14'(mv - rangeBase(range)) + 14'(rangeStep(range) >> 1);
      quotient = offset / 14'(rangeStep(range));
    end
    return (quotient > 14'h00ff) ? 8'hff : code_t'(quotient);
  endfunction

endpackage

// >>> include/supply_link_if.sv
// Purpose: Serial status link between the supervisor and its host.
// Assumes: Host makes linkClk; all other signals change on its falling edge or rising edge.
// Notes: Device samples on rising edges; host drives and samples at falling edges.
`timescale 1ns/1ps
interface supply_link_if;
  logic linkClk;
  logic frameActive;
  logic cmdBit;
  logic replyBit;

  modport host (
    output linkClk,
    output frameActive,
    output cmdBit,
    input replyBit
  );

  modport device (
    input linkClk,
    input frameActive,
    input cmdBit,
    output replyBit
  );
endinterface

// >>> hdl/supply_fault_host.sv
// Purpose: Host end: makes the link clock, reads the live fault summary, encodes thresholds.
// Assumes: DIV_HALF of at least 3 so the resynchronised reply settles before sampling.
// Notes: Link clock is derived from ref_clk, so the link is no separate domain here.
`timescale 1ns/1ps
module supply_fault_host #(
  parameter int DIV_HALF = supply_fault_pkg::LINK_HALF_REF_CYCLES
) (
  supply_link_if.host link,
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic startRead,
  input wire logic [7:0] readCommand,
  input wire supply_fault_pkg::mv_t thrRequestMv,
  input wire logic [1:0] thrRequestRange,
  output logic busy,
  output logic readDone,
  output logic readAck,
  output logic [15:0] readData,
  output supply_fault_pkg::code_t thrCode
);
  import supply_fault_pkg::*;

  // ************************************************************
  // Clock divider
  // ************************************************************
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SEND = 3'b010,
    H_RECV = 3'b100
  } host_state_t;

  localparam logic [7:0] DIV_LAST = 8'(2 * DIV_HALF - 1);
  localparam logic [7:0] DIV_FALL = 8'(DIV_HALF - 1);

  host_state_t state;
  logic [7:0] divCount;
  logic linkClkReg;
  logic fallPoint;
  logic [7:0] next_divCount;
  logic pending;
  logic [7:0] cmdShift;
  logic [4:0] hostBit;
  logic replySync1;
  logic replySync2;

  assign next_divCount = (divCount == DIV_LAST) ? 8'h00 : divCount + 8'h01;
  assign fallPoint = (divCount == DIV_FALL);
  assign link.linkClk = linkClkReg;
  assign busy = pending || (state != H_IDLE);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      divCount <= 8'h00;
      linkClkReg <= 1'b0;
      replySync1 <= 1'b0;
      replySync2 <= 1'b0;
      thrCode <= 8'h00;
    end else begin
      divCount <= next_divCount;
      linkClkReg <= (next_divCount < 8'(DIV_HALF));
      replySync1 <= link.replyBit;
      replySync2 <= replySync1;
      thrCode <= thresholdCode(thrRequestMv, thrRequestRange);
    end
  end

  // ************************************************************
  // Read sequencer
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= H_IDLE;
      pending <= 1'b0;
      cmdShift <= 8'h00;
      hostBit <= 5'h00;
      link.frameActive <= 1'b0;
      link.cmdBit <= 1'b0;
      readDone <= 1'b0;
      readAck <= 1'b0;
      readData <= 16'h0000;
    end else begin
      readDone <= 1'b0;
      // Busy also covers a pending start, so a second start cannot replace its command
      if (startRead && !busy) begin
        pending <= 1'b1;
        cmdShift <= readCommand;
      end
      if (fallPoint) begin
        unique case (state)
          H_IDLE: begin
            if (pending) begin
              pending <= 1'b0;
              link.frameActive <= 1'b1;
              link.cmdBit <= cmdShift[7];
              cmdShift <= {cmdShift[6:0], 1'b0};
              hostBit <= 5'h00;
              state <= H_SEND;
            end
          end
          H_SEND: begin
            if (hostBit == 5'h07) begin
              readAck <= replySync2;
              hostBit <= 5'h00;
              state <= H_RECV;
            end else begin
              link.cmdBit <= cmdShift[7];
              cmdShift <= {cmdShift[6:0], 1'b0};
              hostBit <= hostBit + 5'h01;
            end
          end
          H_RECV: begin
            readData <= {readData[14:0], replySync2};
            hostBit <= hostBit + 5'h01;
            if (hostBit == 5'(REPLY_BITS - 1)) begin
              link.frameActive <= 1'b0;
              link.cmdBit <= 1'b0;
              readDone <= 1'b1;
              state <= H_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule

// >>> sim/supply_link_props.sv
// Purpose: Protocol checks on the status link between host and supervisor.
// Assumes: Frames of 8 command bits, 1 ack bit and 16 data bits.
// Notes: Sampled on link clock rising edges, where the device samples.
`timescale 1ns/1ps
module supply_link_props
  import supply_fault_pkg::*;
(
  input wire logic linkClk,
  input wire logic rst_n,
  input wire logic frameActive,
  input wire logic cmdBit,
  input wire logic replyBit
);
  // ************
  // Frame tracking
  // ************
  logic [4:0] bitCount;
  logic [7:0] cmdSeen;

  always_ff @(posedge linkClk) begin
    if (!rst_n || !frameActive) begin
      bitCount <= 5'h00;
    end else begin
      bitCount <= bitCount + 5'h01;
    end
  end

  always_ff @(posedge linkClk) begin
    if (frameActive && bitCount < 5'h08) begin
      cmdSeen <= {cmdSeen[6:0], cmdBit};
    end
  end

  // ************
  // Properties
  // ************
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (!rst_n);

  sequence quietEight;
    !replyBit [*8];
  endsequence

  // Ack plus all sixteen data bits
  sequence quietReply;
    quietEight ##1 quietEight ##1 !replyBit;
  endsequence

  AST_FRAME_LENGTH: assert property ($fell(frameActive) |-> bitCount == 5'h18)
    else $error("frame not 24 link edges long");
  AST_FRAME_BOUND: assert property (frameActive |-> bitCount < 5'h18)
    else $error("frame overran");
  AST_REFUSED_REPLY: assert property (
    (bitCount == 5'h08 && cmdSeen != CMD_LIVE_FAULT_SUMMARY) |-> quietReply)
    else $error("other command answered");
  AST_RESERVED_HIGH: assert property (
    (bitCount == 5'h09 && cmdSeen == CMD_LIVE_FAULT_SUMMARY) |-> !replyBit [*3])
    else $error("reserved high bits set");
  AST_RESERVED_LOW: assert property (bitCount == 5'h18 |-> !replyBit)
    else $error("reserved bit 0 set");
  AST_CMD_IDLE: assert property (!frameActive |-> !cmdBit)
    else $error("command line busy outside frame");
  AST_REPLY_IDLE: assert property ((!frameActive && !$past(frameActive)) |-> !replyBit)
    else $error("reply line busy outside frame");
  AST_REPLY_BEFORE_ACK: assert property ($rose(frameActive) |-> quietEight)
    else $error("reply before command complete");
endmodule

// >>> sim/supply_fault_status_qualifier_tb.sv
// Purpose: Self-checking bench joining host and supervisor ends over the link.
// Assumes: Three passes, each reloading the device through a reset with other input functions.
// Notes: Load count shortened so the run stays brief.
`timescale 1ns/1ps
module supply_fault_status_qualifier_tb;
  import supply_fault_pkg::*;
  localparam int LOAD = 40;
  localparam int LIMIT = 20000;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic devRst_n = 1'b0;
  logic startRead = 1'b0;
  logic [7:0] readCommand = 8'h00;
  mv_t thrRequestMv = 13'h0000;
  logic [1:0] thrRequestRange = 2'b00;
  logic busy, readDone, readAck, loadDone, clearFaultLog, sysReset_n;
  logic [15:0] readData, liveSummary;
  code_t thrCode;
  flags6_t upperAbove = 6'h00;
  flags6_t lowerAbove = 6'h00;
  logic [1:0] generalInputPin = 2'b11;
  logic [1:0] auxAboveRef = 2'b00;
  word6_t nvSetup, nvThreshold;
  func2_t nvFunction = {FUNC_UV_IGNORE, FUNC_MARGIN_HOLD};
  logic [1:0] nvClearLogEnable, nvResetIncludesMr, auxResult;
  mv6_t upperThresholdMv, lowerThresholdMv;
  logic [3:0] misc;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  integer seed = 32'h3bf53b35;

  supply_link_if linkBus();
  supply_fault_host supply_fault_host_inst (.link(linkBus), .ref_clk(ref_clk), .rst_n(rst_n),
    .startRead(startRead), .readCommand(readCommand), .thrRequestMv(thrRequestMv),
    .thrRequestRange(thrRequestRange), .busy(busy), .readDone(readDone), .readAck(readAck),
    .readData(readData), .thrCode(thrCode));
  supply_fault_device #(.LOAD_CYCLES(LOAD)) supply_fault_device_inst (.link(linkBus),
    .rst_n(devRst_n), .upperAbove(upperAbove), .lowerAbove(lowerAbove),
    .generalInputPin(generalInputPin), .auxAboveRef(auxAboveRef), .nvSetup(nvSetup),
    .nvThreshold(nvThreshold), .nvFunction(nvFunction), .nvClearLogEnable(nvClearLogEnable),
    .nvResetIncludesMr(nvResetIncludesMr), .loadDone(loadDone),
    .upperThresholdMv(upperThresholdMv), .lowerThresholdMv(lowerThresholdMv),
    .liveSummary(liveSummary), .auxResult(auxResult), .clearFaultLog(clearFaultLog),
    .sysReset_n(sysReset_n));
  supply_link_props supply_link_props_inst (.linkClk(linkBus.linkClk), .rst_n(devRst_n),
    .frameActive(linkBus.frameActive), .cmdBit(linkBus.cmdBit), .replyBit(linkBus.replyBit));

  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      tally_and_finish();
    end
  end

  // ************
  // Helpers
  // ************
  task automatic tally_and_finish();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // A stray start in mid-frame must be ignored
  task automatic doRead(input logic [7:0] cmd);
    int n;
    n = 0;
    @(posedge ref_clk);
    readCommand <= cmd;
    startRead <= 1'b1;
    @(posedge ref_clk);
    startRead <= 1'b0;
    #1;
    check(busy, 1'b1);
    while (readDone !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      startRead <= (n == 50);
      if (n == 50) readCommand <= 8'h00;
      #1;
      n++;
    end
    if (n == 400) failures++;
    check(busy, 1'b0);
  endtask

  function automatic mv_t expMv(input code_t c, input logic [1:0] r);
    return (r == 2'b00) ? mv_t'(13'h384 + 13'h014 * c) :
      (r == 2'b01) ? mv_t'(13'h1c2 + 13'h00a * c) : mv_t'(13'h0b4 + 13'h004 * c);
  endfunction

  function automatic code_t expCode(input mv_t mv, input logic [1:0] r);
    int b, s, q;
    b = (r == 2'b00) ? 16'h0384 : (r == 2'b01) ? 16'h01c2 : 16'h00b4;
    s = (r == 2'b00) ? 16'h0014 : (r == 2'b01) ? 16'h000a : 16'h0004;
    q = (int'(mv) > b) ? (int'(mv) - b + s / 2) / s : 0;
    return (q > 255) ? 8'hff : code_t'(q);
  endfunction

  function automatic logic [15:0] expSum(input flags6_t up, input flags6_t lo,
                                         input logic [1:0] pin);
    logic [15:0] sum;
    logic us, ls, mg, uv;
    sum = 16'h0000;
    mg = 1'b0;
    uv = 1'b0;
    for (int j = 0; j < NUM_INPUTS; j++) begin
      mg = mg || (nvFunction[j] == FUNC_MARGIN_HOLD && !pin[j]);
      uv = uv || (nvFunction[j] == FUNC_UV_IGNORE && !pin[j]);
    end
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      us = nvSetup[i][SETUP_UPPER_SENSE_BIT];
      ls = nvSetup[i][SETUP_LOWER_SENSE_BIT];
      sum[2 * i + 2] = (us ? up[i] : !up[i]) && !mg && (us || !uv);
      sum[2 * i + 1] = (ls ? lo[i] : !lo[i]) && !mg && (ls || !uv);
    end
    return sum;
  endfunction

  // {auxResult, clearFaultLog, sysReset_n} for the loaded configuration
  function automatic logic [3:0] expMisc(input logic [15:0] sum, input logic [1:0] pin,
                                         input logic [1:0] aux);
    logic [3:0] r;
    logic mr;
    r = 4'h1;
    for (int j = 0; j < NUM_INPUTS; j++) begin
      mr = (nvFunction[j] == FUNC_MANUAL_RESET) && !pin[j];
      r[2 + j] = ((nvFunction[j] == FUNC_AUX_NONINV) && aux[j]) ||
        ((nvFunction[j] == FUNC_AUX_INV) && !aux[j]);
      r[1] = r[1] || (mr && nvClearLogEnable[j]);
      r[0] = r[0] && !(mr && nvResetIncludesMr[j]);
    end
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      r[0] = r[0] && !(sum[2 * i + 2] && nvSetup[i][SETUP_UPPER_TO_RESET_BIT]) &&
        !(sum[2 * i + 1] && nvSetup[i][SETUP_LOWER_TO_RESET_BIT]);
    end
    return r;
  endfunction

  // ************
  // Main sequence
  // ************
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Configuration is static, so each pass swaps it while the device is held in reset
    for (int p = 0; p < 3; p++) begin
      @(posedge linkBus.linkClk);
      devRst_n <= 1'b0;
      nvFunction <= (p == 0) ? {FUNC_UV_IGNORE, FUNC_MARGIN_HOLD} :
        (p == 1) ? {FUNC_AUX_INV, FUNC_MANUAL_RESET} : {FUNC_MANUAL_RESET, FUNC_AUX_NONINV};
      nvClearLogEnable <= 2'($random(seed));
      nvResetIncludesMr <= 2'($random(seed));
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        nvSetup[i] <= {6'h00, 2'($random(seed)), 2'($random(seed)), 2'h0, 1'($random(seed)),
                       2'h0, 1'($random(seed))};
        nvThreshold[i] <= 16'($random(seed));
      end
      nvSetup[5] <= UNUSED_SETUP;
      nvThreshold[5] <= UNUSED_THRESHOLD;
      repeat (4) @(posedge linkBus.linkClk);
      devRst_n <= 1'b1;
      doRead(CMD_LIVE_FAULT_SUMMARY);
      check(readAck, 1'b0);
      check(readData, 16'h0000);
      for (int n = 0; n < 400 && loadDone !== 1'b1; n++) @(posedge ref_clk);
      check(loadDone, 1'b1);
      // Levels follow the loaded words one link edge after the load
      repeat (2) @(posedge linkBus.linkClk);
      #1;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        check(upperThresholdMv[i], expMv(nvThreshold[i][15:8], nvSetup[i][9:8]));
        check(lowerThresholdMv[i], expMv(nvThreshold[i][7:0], nvSetup[i][9:8]));
      end
      doRead(8'($random(seed)) | 8'h80);
      check({readAck, readData}, 17'h00000);
      for (int k = 0; k < 10; k++) begin
        @(posedge ref_clk);
        upperAbove <= {1'b0, 5'($random(seed))};
        lowerAbove <= {1'b0, 5'($random(seed))};
        generalInputPin <= (k < 4) ? 2'(k) : 2'($random(seed));
        auxAboveRef <= 2'($random(seed));
        thrRequestMv <= (k == 0) ? 13'h0000 : (k == 1) ? 13'h1fff : 13'($random(seed));
        thrRequestRange <= 2'(k);
        repeat (40) @(posedge ref_clk);
        #1;
        check(thrCode, expCode(thrRequestMv, thrRequestRange));
        check(liveSummary, expSum(upperAbove, lowerAbove, generalInputPin));
        misc = expMisc(expSum(upperAbove, lowerAbove, generalInputPin), generalInputPin,
                       auxAboveRef);
        check(auxResult, misc[3:2]);
        check({clearFaultLog, sysReset_n}, misc[1:0]);
        doRead(CMD_LIVE_FAULT_SUMMARY);
        check(readAck, 1'b1);
        check(readData, expSum(upperAbove, lowerAbove, generalInputPin));
      end
    end
    tally_and_finish();
  end
endmodule
